// ===== logic/sram_burst_pkg.sv
// shared constants for the four-beat split-port sram sequencer and its controller
// assumes both ends run on one sys_clk; the link strobe k toggles once per enabled cycle except while the controller is stopped
`default_nettype none

package sram_burst_pkg;

  // --------------------------------------------------------------------------
  // data layout
  // --------------------------------------------------------------------------
  localparam int LANE_W     = 9;
  localparam int LANES      = 2;
  localparam int WORD_W     = LANE_W * LANES;
  localparam int BURST_LEN  = 4;
  localparam int DEF_ADDR_W = 6;
  localparam int MIN_ADDR_W = 2;
  localparam int MAX_ADDR_W = 12;
  localparam int BUF_ENTRIES = 2;

  // --------------------------------------------------------------------------
  // half-cycle positions after the primary edge that took the command
  // --------------------------------------------------------------------------
  localparam int WR_BEAT_POS   = 4;
  localparam int RD_BEAT_POS   = 5;
  localparam int WR_PIPE_LEN   = WR_BEAT_POS + BURST_LEN - 1;
  localparam int RD_PIPE_LEN   = RD_BEAT_POS + BURST_LEN - 1;
  localparam int CAP_BEAT_POS  = 7;
  localparam int CAP_PIPE_LEN  = CAP_BEAT_POS + BURST_LEN - 1;

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic RST_SEL_N   = 1'h1;
  localparam logic RST_K       = 1'h0;
  localparam logic RST_IDLE    = 1'h1;

  typedef logic [WORD_W-1:0] word_type;
  typedef logic [LANES-1:0]  lane_type;

endpackage

`default_nettype wire

// ===== logic/sram_link_if.sv
// link between the sram sequencer and the memory controller
// assumes one common sys_clk; the controller drives the strobe k
`timescale 1ns/100ps
`default_nettype none

interface sram_link_if
  import sram_burst_pkg::*;
#(parameter int ADDR_W = DEF_ADDR_W);

  logic              k;
  logic              read_sel_n;
  logic              write_sel_n;
  logic [ADDR_W-1:0] addr;
  word_type          wdata;
  logic              lane0_write_mask_n;
  logic              lane1_write_mask_n;
  word_type          rdata;
  logic              rdata_oe_n;

  modport dev (
    input  k, read_sel_n, write_sel_n, addr, wdata,
    input  lane0_write_mask_n, lane1_write_mask_n,
    output rdata, rdata_oe_n
  );

  modport ctrl (
    output k, read_sel_n, write_sel_n, addr, wdata,
    output lane0_write_mask_n, lane1_write_mask_n,
    input  rdata, rdata_oe_n
  );

endinterface // sram_link_if

`default_nettype wire

// ===== logic/burst4_sram_dev.sv
// sram side: command capture, burst sequencing, write buffers and the array
// assumes the controller drives k from the same sys_clk and keeps its own rules
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - burst addresses are start plus 0..3, linear
// - read select low at primary edge requests read
// - write select low at primary edge requests write
// - read and write sequencers run independently
// - commands sampled, sequencers advanced on strobe edges
// - controller issues read at t, write at t+1
// - controller drains bursts before stopping the strobe
// - controller starts reads every other edge, writes every fourth
// - same-type command on next edge is dropped
// - both selects after idle edge: read wins
// - beats count only for a taken write
// - active-low lane masks gate each beat's lanes
// - last two writes buffered, reads forwarded
module burst4_sram_dev
  import sram_burst_pkg::*;
#(
  parameter int ADDR_W = DEF_ADDR_W
)
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // link to the controller
  sram_link_if.dev  link,
  // status
  output logic      rd_active,
  output logic      wr_active
);

  // --------------------------------------------------------------------------
  // parameter check
  // --------------------------------------------------------------------------
  generate
    if (ADDR_W < MIN_ADDR_W || ADDR_W > MAX_ADDR_W) begin : g_bad_addr_w
      $error("ADDR_W out of the supported range");
    end
  endgenerate

  localparam int DEPTH = 1 << ADDR_W;

  typedef logic [ADDR_W-1:0] addr_type;

  // --------------------------------------------------------------------------
  // strobe edges
  // --------------------------------------------------------------------------
  logic k_prev_ff;
  logic tick;
  logic prim;

  // every k transition is one half-cycle; a stopped strobe gives no ticks
  assign tick = clk_en & (link.k ^ k_prev_ff);
  assign prim = tick & link.k;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      k_prev_ff <= RST_K;
    end else if (clk_en) begin
      k_prev_ff <= link.k;
    end
  end

  // --------------------------------------------------------------------------
  // command capture
  // --------------------------------------------------------------------------
  logic rd_req;
  logic wr_req;
  logic rd_acc;
  logic wr_acc;
  logic rd_last_ff;
  logic wr_last_ff;
  logic idle_last_ff;

  assign rd_req = prim & ~link.read_sel_n;
  assign wr_req = prim & ~link.write_sel_n;
  assign rd_acc = rd_req & ~rd_last_ff;
  // after an idle slot a simultaneous read and write keeps only the read
  assign wr_acc = wr_req & ~wr_last_ff & ~(rd_req & idle_last_ff);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_last_ff   <= 1'h0;
      wr_last_ff   <= 1'h0;
      idle_last_ff <= RST_IDLE;
    end else if (prim) begin
      rd_last_ff   <= rd_acc;
      wr_last_ff   <= wr_acc;
      idle_last_ff <= link.read_sel_n & link.write_sel_n;
    end
  end

  // --------------------------------------------------------------------------
  // read and write sequencers
  // --------------------------------------------------------------------------
  logic [RD_PIPE_LEN:1] rd_v_ff;
  addr_type             rd_a_ff [1:RD_PIPE_LEN];
  logic [WR_PIPE_LEN:1] wr_v_ff;
  logic                 wr_i_ff [1:WR_PIPE_LEN];
  logic                 wr_ptr_ff;

  // two separate shift lines, so a read and a write can hold the same position at once
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_v_ff <= '0;
      for (int p = 1; p <= RD_PIPE_LEN; p++) begin
        rd_a_ff[p] <= '0;
      end
    end else if (tick) begin
      rd_v_ff    <= {rd_v_ff[RD_PIPE_LEN-1:1], rd_acc};
      rd_a_ff[1] <= link.addr;
      for (int p = 2; p <= RD_PIPE_LEN; p++) begin
        rd_a_ff[p] <= rd_a_ff[p-1];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_v_ff <= '0;
      for (int p = 1; p <= WR_PIPE_LEN; p++) begin
        wr_i_ff[p] <= 1'h0;
      end
    end else if (tick) begin
      wr_v_ff    <= {wr_v_ff[WR_PIPE_LEN-1:1], wr_acc};
      wr_i_ff[1] <= wr_ptr_ff;
      for (int p = 2; p <= WR_PIPE_LEN; p++) begin
        wr_i_ff[p] <= wr_i_ff[p-1];
      end
    end
  end

  assign rd_active = |rd_v_ff;
  assign wr_active = |wr_v_ff;

  // --------------------------------------------------------------------------
  // write buffers
  // --------------------------------------------------------------------------
  logic     buf_v_ff  [BUF_ENTRIES];
  addr_type buf_a_ff  [BUF_ENTRIES];
  word_type buf_d_ff  [BUF_ENTRIES][BURST_LEN];
  lane_type buf_en_ff [BUF_ENTRIES][BURST_LEN];
  lane_type beat_en;

  // masks are active low; all lanes masked leaves the beat unwritten
  assign beat_en = ~{link.lane1_write_mask_n, link.lane0_write_mask_n};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= 1'h0;
      for (int e = 0; e < BUF_ENTRIES; e++) begin
        buf_v_ff[e] <= 1'h0;
        buf_a_ff[e] <= '0;
        for (int b = 0; b < BURST_LEN; b++) begin
          buf_d_ff[e][b]  <= '0;
          buf_en_ff[e][b] <= '0;
        end
      end
    end else if (tick) begin
      if (wr_acc) begin
        buf_v_ff[wr_ptr_ff] <= 1'h1;
        buf_a_ff[wr_ptr_ff] <= link.addr;
        for (int b = 0; b < BURST_LEN; b++) begin
          buf_en_ff[wr_ptr_ff][b] <= '0;
        end
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      for (int p = WR_BEAT_POS; p <= WR_PIPE_LEN; p++) begin
        if (wr_v_ff[p]) begin
          buf_d_ff[wr_i_ff[p]][p-WR_BEAT_POS]  <= link.wdata;
          buf_en_ff[wr_i_ff[p]][p-WR_BEAT_POS] <= beat_en;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // array; the oldest buffer is committed when a third write arrives
  // --------------------------------------------------------------------------
  word_type mem_ff [DEPTH];

  // the array holds data only, so it is left out of reset to stay cheap
  always_ff @(posedge sys_clk) begin
    if (tick && wr_acc && buf_v_ff[wr_ptr_ff]) begin
      for (int b = 0; b < BURST_LEN; b++) begin
        for (int l = 0; l < LANES; l++) begin
          if (buf_en_ff[wr_ptr_ff][b][l]) begin
            mem_ff[buf_a_ff[wr_ptr_ff] + addr_type'(b)][l*LANE_W +: LANE_W] <=
              buf_d_ff[wr_ptr_ff][b][l*LANE_W +: LANE_W];
          end
        end
      end
    end
  end

  // read one word, overlaid lane by lane with the older then newer buffer
  function automatic word_type fetch(input addr_type wa);
    word_type w;
    addr_type off;
    logic     idx;
    w = mem_ff[wa];
    for (int k = 0; k < BUF_ENTRIES; k++) begin
      idx = wr_ptr_ff ^ k[0];
      off = wa - buf_a_ff[idx];
      if (buf_v_ff[idx] && off <= addr_type'(BURST_LEN - 1)) begin
        for (int l = 0; l < LANES; l++) begin
          if (buf_en_ff[idx][off[1:0]][l]) begin
            w[l*LANE_W +: LANE_W] = buf_d_ff[idx][off[1:0]][l*LANE_W +: LANE_W];
          end
        end
      end
    end
    return w;
  endfunction

  // --------------------------------------------------------------------------
  // read data out
  // --------------------------------------------------------------------------
  word_type q_ff;
  logic     q_oe_n_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q_ff      <= '0;
      q_oe_n_ff <= 1'h1;
    end else if (tick) begin
      q_oe_n_ff <= 1'h1;
      for (int p = RD_BEAT_POS; p <= RD_PIPE_LEN; p++) begin
        if (rd_v_ff[p]) begin
          q_ff      <= fetch(rd_a_ff[p] + addr_type'(p - RD_BEAT_POS));
          q_oe_n_ff <= 1'h0;
        end
      end
    end
  end

  assign link.rdata      = q_ff;
  assign link.rdata_oe_n = q_oe_n_ff;

endmodule // burst4_sram_dev

`default_nettype wire

// ===== logic/burst4_sram_ctrl.sv
// controller side: makes the strobe, issues commands, drives and captures beats
// assumes the sram end shares sys_clk and answers on the same half-cycle grid
`timescale 1ns/100ps
`default_nettype none

module burst4_sram_ctrl
  import sram_burst_pkg::*;
#(
  parameter int ADDR_W = DEF_ADDR_W
)
(
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic                        clk_en,
  // link to the sram
  sram_link_if.ctrl                        link,
  // read request
  input  wire logic                        rd_valid,
  input  wire logic [ADDR_W-1:0]           rd_addr,
  output logic                             rd_ready,
  // write request
  input  wire logic                        wr_valid,
  input  wire logic [ADDR_W-1:0]           wr_addr,
  input  wire logic [BURST_LEN*WORD_W-1:0] wr_data,
  input  wire logic [BURST_LEN*LANES-1:0]  wr_mask_n,
  output logic                             wr_ready,
  // read answer
  output logic                             rsp_valid,
  output logic [BURST_LEN*WORD_W-1:0]      rsp_data,
  // strobe stop
  input  wire logic                        stop_req,
  output logic                             stopped
);

  generate
    if (ADDR_W < MIN_ADDR_W || ADDR_W > MAX_ADDR_W) begin : g_bad_addr_w
      $error("ADDR_W out of the supported range");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // strobe and issue
  // --------------------------------------------------------------------------
  logic                    k_ff;
  logic                    run_ff;
  logic                    rd_last_ff;
  logic [CAP_PIPE_LEN:1]   cr_v_ff;
  logic [WR_PIPE_LEN:1]    cw_v_ff;
  logic                    tick;
  logic                    rise;
  logic                    drained;
  logic                    stop_now;

  // the stopping edge must not toggle k, so the strobe rests low while stopped
  assign stop_now = run_ff & ~k_ff & stop_req & drained;
  assign tick     = clk_en & run_ff & ~stop_now;
  assign rise     = tick & ~k_ff;
  assign drained  = ~|cr_v_ff & ~|cw_v_ff;
  // reads take precedence; a write waits until the previous write's beats are out,
  // which trades write throughput for a single data holding register
  assign rd_ready = rise & ~stop_req & rd_valid & ~rd_last_ff;
  assign wr_ready = rise & ~stop_req & wr_valid & ~rd_ready & ~|cw_v_ff[WR_PIPE_LEN-1:1];
  assign stopped  = ~run_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      k_ff   <= RST_K;
      run_ff <= 1'h1;
    end else if (clk_en) begin
      if (tick) begin
        k_ff <= ~k_ff;
      end
      // stop only with k low and every burst drained
      if (stop_now) begin
        run_ff <= 1'h0;
      end else if (!run_ff && !stop_req) begin
        run_ff <= 1'h1;
      end
    end
  end

  logic              rsel_n_ff;
  logic              wsel_n_ff;
  logic [ADDR_W-1:0] addr_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_last_ff <= 1'h0;
      rsel_n_ff  <= RST_SEL_N;
      wsel_n_ff  <= RST_SEL_N;
      addr_ff    <= '0;
    end else if (rise) begin
      rd_last_ff <= rd_ready;
      rsel_n_ff  <= ~rd_ready;
      wsel_n_ff  <= ~wr_ready;
      if (rd_ready) begin
        addr_ff <= rd_addr;
      end else if (wr_ready) begin
        addr_ff <= wr_addr;
      end
    end
  end

  // --------------------------------------------------------------------------
  // write beats
  // --------------------------------------------------------------------------
  logic [BURST_LEN*WORD_W-1:0] wd_ff;
  logic [BURST_LEN*LANES-1:0]  wm_ff;
  word_type                    wdata_ff;
  lane_type                    wmask_n_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cw_v_ff    <= '0;
      wd_ff      <= '0;
      wm_ff      <= '1;
      wdata_ff   <= '0;
      wmask_n_ff <= '1;
    end else if (tick) begin
      cw_v_ff <= {cw_v_ff[WR_PIPE_LEN-1:1], wr_ready};
      if (wr_ready) begin
        wd_ff <= wr_data;
        wm_ff <= wr_mask_n;
      end
      wmask_n_ff <= '1;
      for (int p = WR_BEAT_POS; p <= WR_PIPE_LEN; p++) begin
        if (cw_v_ff[p]) begin
          wdata_ff   <= wd_ff[(p-WR_BEAT_POS)*WORD_W +: WORD_W];
          wmask_n_ff <= wm_ff[(p-WR_BEAT_POS)*LANES +: LANES];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // read capture
  // --------------------------------------------------------------------------
  logic                        rsp_valid_ff;
  logic [BURST_LEN*WORD_W-1:0] rsp_data_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cr_v_ff      <= '0;
      rsp_valid_ff <= 1'h0;
      rsp_data_ff  <= '0;
    end else if (clk_en) begin
      rsp_valid_ff <= tick & cr_v_ff[CAP_PIPE_LEN];
      if (tick) begin
        cr_v_ff <= {cr_v_ff[CAP_PIPE_LEN-1:1], rd_ready};
        for (int p = CAP_BEAT_POS; p <= CAP_PIPE_LEN; p++) begin
          if (cr_v_ff[p]) begin
            rsp_data_ff[(p-CAP_BEAT_POS)*WORD_W +: WORD_W] <= link.rdata;
          end
        end
      end
    end
  end

  assign rsp_valid               = rsp_valid_ff;
  assign rsp_data                = rsp_data_ff;
  assign link.k                  = k_ff;
  assign link.read_sel_n         = rsel_n_ff;
  assign link.write_sel_n        = wsel_n_ff;
  assign link.addr               = addr_ff;
  assign link.wdata              = wdata_ff;
  assign link.lane0_write_mask_n = wmask_n_ff[0];
  assign link.lane1_write_mask_n = wmask_n_ff[1];

endmodule // burst4_sram_ctrl

`default_nettype wire

// ===== test/burst4_split_port_sram_ctrl_monitor.sv
// link checker: strobe, selects, lane masks and read enable of one link
// assumes both ends share sys_clk; instantiated beside the joining interface
`timescale 1ns/100ps
`default_nettype none

module burst4_split_port_sram_ctrl_monitor
  import sram_burst_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // link
  input wire logic k,
  input wire logic read_sel_n,
  input wire logic write_sel_n,
  input wire logic lane0_write_mask_n,
  input wire logic lane1_write_mask_n,
  input wire logic rdata_oe_n
);
  // ---------------------------------------------------------------------
  // primary edge detect
  // ---------------------------------------------------------------------
  logic      k_q_ff;
  wire logic prim     = k & ~k_q_ff;
  wire logic rd_cmd   = prim & ~read_sel_n;
  wire logic wr_cmd   = prim & ~write_sel_n;
  wire logic mask_any = ~lane0_write_mask_n | ~lane1_write_mask_n;

  // gated like the design, so positions count enabled edges only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      k_q_ff <= RST_K;
    end else if (clk_en) begin
      k_q_ff <= k;
    end
  end

  // ---------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk iff clk_en);
  endclocking
  default disable iff (rst);

  a_read_beat_timing: assert property (rd_cmd |-> ##6 !rdata_oe_n [*4])
    else $error("read beats missing at positions five to eight");
  a_read_burst_end: assert property ($rose(rdata_oe_n) |-> $past(rd_cmd, 10))
    else $error("read beats ended off position");
  a_idle_slot_hiz: assert property ($fell(rdata_oe_n) |-> $past(rd_cmd, 6))
    else $error("read output enabled without a read");
  a_read_spacing: assert property (rd_cmd |-> ##2 !rd_cmd)
    else $error("read on consecutive rises");
  a_write_spacing: assert property (wr_cmd |-> ##2 !wr_cmd)
    else $error("write on consecutive rises");
  a_no_joint_cmd: assert property (prim |-> (read_sel_n || write_sel_n))
    else $error("read and write on one rise");
  a_beats_after_write: assert property (mask_any |->
    ($past(wr_cmd, 4) || $past(wr_cmd, 5) || $past(wr_cmd, 6) || $past(wr_cmd, 7)))
    else $error("lane mask active outside write beats");
  a_stop_drained: assert property ($stable(k) |-> rdata_oe_n)
    else $error("strobe held with read beats pending");

  c_read: cover property (rd_cmd);
  c_read_write: cover property (rd_cmd ##2 wr_cmd);
  c_stop: cover property ($stable(k) [*3]);

endmodule // burst4_split_port_sram_ctrl_monitor

`default_nettype wire

// ===== test/burst4_split_port_sram_ctrl_tb.sv
// bench: controller and sram end on one link, a bench-driven second sram end,
// a word model of the array and a queue of expected read bursts
// assumes the package, the link interface and both design modules come first
`timescale 1ns/100ps
`default_nettype none

module burst4_split_port_sram_ctrl_tb
  import sram_burst_pkg::*;
;
  localparam int AW = 4;
  localparam int BW = BURST_LEN * WORD_W;

  // -------------------------------------------------------------------------
  // stimulus and bookkeeping
  // -------------------------------------------------------------------------
  logic          sys_clk    = 1'b0;
  logic          rst        = 1'b1;
  logic          clk_en     = 1'b1;
  logic          jitter     = 1'b0;
  logic          rd_valid   = 1'b0;
  logic [AW-1:0] rd_addr    = '0;
  logic          wr_valid   = 1'b0;
  logic [AW-1:0] wr_addr    = '0;
  logic [BW-1:0] wr_data    = '0;
  logic [7:0]    wr_mask_n  = 8'hFF;
  logic          stop_req   = 1'b0;
  logic          rd_ready;
  logic          wr_ready;
  logic          rsp_valid;
  logic [BW-1:0] rsp_data;
  logic          stopped;
  logic          wr_active2;
  logic          rd_act;
  logic          wr_act;
  integer        seed       = 32'hDD8DE8C2;
  integer        bad_count  = 0;
  integer        n_compared = 0;
  integer        cyc        = 0;
  integer        low2       = 0;
  integer        wact2      = 0;
  word_type      mem [0:(1<<AW)-1];
  logic [BW-1:0] exp_q [$];

  sram_link_if #(.ADDR_W(AW)) link ();
  sram_link_if #(.ADDR_W(AW)) link2 ();

  burst4_sram_dev #(.ADDR_W(AW)) u_burst4_sram_dev (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .link(link),
    .rd_active(rd_act), .wr_active(wr_act));
  // second sram end, facing the bench instead of the controller
  burst4_sram_dev #(.ADDR_W(AW)) u_burst4_sram_dev_b (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .link(link2),
    .rd_active(), .wr_active(wr_active2));
  burst4_sram_ctrl #(.ADDR_W(AW)) u_burst4_sram_ctrl (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .link(link),
    .rd_valid(rd_valid), .rd_addr(rd_addr), .rd_ready(rd_ready),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_mask_n(wr_mask_n), .wr_ready(wr_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .stop_req(stop_req), .stopped(stopped));
  burst4_split_port_sram_ctrl_monitor u_burst4_split_port_sram_ctrl_monitor (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .k(link.k),
    .read_sel_n(link.read_sel_n), .write_sel_n(link.write_sel_n),
    .lane0_write_mask_n(link.lane0_write_mask_n),
    .lane1_write_mask_n(link.lane1_write_mask_n), .rdata_oe_n(link.rdata_oe_n));

  // -------------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------------
  task automatic check(input logic [BW-1:0] seen, input logic [BW-1:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wait_hi(ref logic s);
    integer n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n = n + 1;
    end while (s !== 1'b1 && n < 300);
    if (s !== 1'b1) begin
      bad_count = bad_count + 1;
      $display("ERROR %0t: handshake wait ran out", $time);
      give_verdict();
    end
  endtask

  function automatic logic [BW-1:0] rnd();
    return BW'({$random(seed), $random(seed), $random(seed)});
  endfunction

  task automatic do_write(input logic [AW-1:0] a, input logic [BW-1:0] d,
                          input logic [7:0] m);
    logic [AW-1:0] idx;
    wr_valid <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    wr_mask_n <= m;
    wait_hi(wr_ready);
    for (int b = 0; b < BURST_LEN; b++) begin
      idx = a + AW'(b);
      if (!m[2*b]) mem[idx][8:0] = d[18*b +: 9];
      if (!m[2*b+1]) mem[idx][17:9] = d[18*b+9 +: 9];
    end
    wr_valid <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic do_read(input logic [AW-1:0] a, output integer t);
    logic [BW-1:0] e;
    rd_valid <= 1'b1;
    rd_addr <= a;
    wait_hi(rd_ready);
    t = cyc;
    for (int b = 0; b < BURST_LEN; b++) e[18*b +: 18] = mem[a + AW'(b)];
    exp_q.push_back(e);
    rd_valid <= 1'b0;
    @(posedge sys_clk);
  endtask

  // one strobe period on the second link, selects valid at its rise
  task automatic fire2(input logic rs, input logic ws);
    @(posedge sys_clk);
    link2.k <= 1'b1;
    link2.read_sel_n <= rs;
    link2.write_sel_n <= ws;
    @(posedge sys_clk);
    link2.k <= 1'b0;
    link2.read_sel_n <= 1'b1;
    link2.write_sel_n <= 1'b1;
  endtask

  // -------------------------------------------------------------------------
  // clock, responses, sequence
  // -------------------------------------------------------------------------
  always #50 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    clk_en <= jitter ? ($random(seed) % 4 != 0) : 1'b1;
    if (link2.rdata_oe_n === 1'b0) low2 <= low2 + 1;
    if (wr_active2 === 1'b1) wact2 <= wact2 + 1;
    // a frozen edge keeps the pulse up, so it is taken only where the design advances
    if (rsp_valid === 1'b1 && clk_en === 1'b1) begin
      if (exp_q.size() == 0) check(BW'(0), BW'(1));
      else check(rsp_data, exp_q.pop_front());
    end
  end

  initial begin
    integer t0, t1, low0, wact0;
    link2.k = 1'b0;
    link2.read_sel_n = 1'b1;
    link2.write_sel_n = 1'b1;
    link2.addr = '0;
    link2.wdata = '0;
    link2.lane0_write_mask_n = 1'b1;
    link2.lane1_write_mask_n = 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    // fill every word so later reads are defined
    for (int i = 0; i < (1<<AW); i += BURST_LEN) do_write(AW'(i), rnd(), 8'h00);
    // masked writes at random starts, read straight back through the buffers
    repeat (16) begin
      t1 = $random(seed);
      do_write(AW'(t1), rnd(), 8'($random(seed)));
      do_read(AW'(t1), t0);
    end
    // back-to-back reads
    for (int i = 0; i < 6; i++) begin
      do_read(AW'($random(seed)), t1);
      if (i > 0) check(BW'(t1 - t0), BW'(4));
      t0 = t1;
    end
    // disjoint reads and writes in flight together, enable gaps meanwhile
    jitter <= 1'b1;
    fork
      repeat (6) do_write(AW'(($random(seed) & 1) * 4), rnd(), 8'($random(seed)));
      repeat (6) do_read(AW'(8 + ($random(seed) & 1) * 4), t1);
    join
    jitter <= 1'b0;
    // strobe stop after draining, then resume
    stop_req <= 1'b1;
    wait_hi(stopped);
    repeat (6) @(posedge sys_clk);
    check(BW'({link.k, link.rdata_oe_n}), BW'(1));
    check(BW'(exp_q.size()), BW'(0));
    check(BW'({rd_act, wr_act}), BW'(0));
    stop_req <= 1'b0;
    do_read(AW'(3), t0);
    // second end: a read repeated on the next rise is dropped
    fire2(1'b1, 1'b1);
    low0 = low2;
    fire2(1'b0, 1'b1);
    fire2(1'b0, 1'b1);
    repeat (8) fire2(1'b1, 1'b1);
    check(BW'(low2 - low0), BW'(4));
    // both selects after an idle rise: read kept, write dropped
    low0 = low2;
    wact0 = wact2;
    fire2(1'b0, 1'b0);
    repeat (8) fire2(1'b1, 1'b1);
    check(BW'(low2 - low0), BW'(4));
    check(BW'(wact2 - wact0), BW'(0));
    repeat (20) @(posedge sys_clk);
    check(BW'(exp_q.size()), BW'(0));
    give_verdict();
  end

endmodule // burst4_split_port_sram_ctrl_tb

`default_nettype wire
